// ==== rtl/spi_port_map.vh ====
`ifndef SPI_PORT_MAP_VH
`define SPI_PORT_MAP_VH
// ----------------------------------------
// Register indexes (byte address = 4 x index)
// ----------------------------------------
`define IDX_PRIO_LOW 8'hBA
`define IDX_PRIO_HIGH 8'hBB
`define IDX_CONTROL 8'hBC
`define IDX_STATUS 8'hBD
`define IDX_DATA 8'hBE
`define IDX_IRQ_ENABLE 8'hC0
`define IDX_IRQ_MASK 8'hC1
`define IDX_IRQ_STATUS 8'hC2
// ----------------------------------------
// Control fields
// ----------------------------------------
`define CTL_ENABLE 7
`define CTL_MASTER 6
`define CTL_CLOCK_IDLE_LEVEL 5
`define CTL_SAMPLE_EDGE_SELECT 4
`define CTL_SELECT_PIN_DISABLE 3
`define CTL_BIT_ORDER_SELECT 2
// ----------------------------------------
// Status fields
// ----------------------------------------
`define ST_DONE 7
`define ST_WRITE_COLLISION_FLAG 6
`define ST_MODE_FAULT_FLAG 5
`define ST_OVF 4
`define ST_FULL 3
`define ST_BUSY 2
// ----------------------------------------
// Other fields and reset values
// ----------------------------------------
`define PRIO_BIT 4
`define IE_PORT 0
`define IE_GLOBAL 1
`define RST_BYTE 8'h00
`endif

// ==== rtl/spi_shifter.v ====
`include "spi_port_map.vh"
module spi_shifter #(
    parameter W = 8
) (
    input wire hclk,
    input wire hresetn,
    input wire active,
    input wire master,
    input wire clock_idle_level,
    input wire sample_edge_select,
    input wire bit_order_select,
    input wire [1:0] rate,
    input wire load,
    input wire [W-1:0] load_data,
    input wire sck_in,
    input wire ss_active,
    input wire miso_in,
    input wire mosi_in,
    output reg sck_out,
    output reg data_out,
    output reg busy,
    output reg done,
    output reg [W-1:0] rx_data
);
    // ----------------------------------------
    // Shift engine
    // ----------------------------------------
    reg [W-1:0] shreg;
    reg [3:0] div_cnt;
    reg [4:0] edge_cnt;
    reg sck_prev;
    reg [1:0] smp_d;
    reg [W-1:0] rxsh;
    wire [3:0] div_top = (4'h1 << rate) - 4'h1;
    wire serial_in = master ? miso_in : mosi_in;
    wire s_rise = sck_in & ~sck_prev;
    wire s_fall = ~sck_in & sck_prev;
    wire lead = clock_idle_level ? s_fall : s_rise;
    wire trail = clock_idle_level ? s_rise : s_fall;
    wire m_tick = busy && master && !edge_cnt[4] && (div_cnt == div_top);
    wire s_edge = busy && !master && ss_active && !edge_cnt[4] && (lead | trail);
    wire edge_any = m_tick | s_edge;
    wire is_first = ~edge_cnt[0];
    wire sample = is_first ^ sample_edge_select;
    // Master input lags its own clock edge by the two pin flops
    wire strobe = master ? smp_d[1] : (s_edge && sample);
    wire fin = busy && edge_cnt[4] && (smp_d == 2'b00);
    wire out_bit = bit_order_select ? shreg[0] : shreg[W-1];

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shreg <= `RST_BYTE;
            div_cnt <= 4'h0;
            edge_cnt <= 5'd0;
            sck_prev <= 1'b1;
            smp_d <= 2'b00;
            rxsh <= `RST_BYTE;
            sck_out <= 1'b0;
            data_out <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            rx_data <= `RST_BYTE;
        end else begin
            sck_prev <= sck_in;
            done <= 1'b0;
            div_cnt <= m_tick ? 4'h0 : (busy ? div_cnt + 4'h1 : 4'h0);
            smp_d <= {smp_d[0], m_tick && sample};
            if (strobe)
                rxsh <= bit_order_select ? {serial_in, rxsh[W-1:1]} : {rxsh[W-2:0], serial_in};
            if (!active) begin
                busy <= 1'b0;
                sck_out <= clock_idle_level;
            end else if (load) begin
                shreg <= load_data;
                busy <= master;
                edge_cnt <= 5'd0;
                sck_out <= clock_idle_level;
                data_out <= bit_order_select ? load_data[0] : load_data[W-1];
            end else begin
                if (!busy)
                    sck_out <= clock_idle_level;
                if (!master && ss_active && !busy) begin
                    busy <= 1'b1;
                    edge_cnt <= 5'd0;
                    data_out <= out_bit;
                end
                if (edge_any) begin
                    if (master)
                        sck_out <= ~sck_out;
                    edge_cnt <= edge_cnt + 5'd1;
                    if (sample) begin
                        if (bit_order_select)
                            shreg <= {serial_in, shreg[W-1:1]};
                        else
                            shreg <= {shreg[W-2:0], serial_in};
                    end else if (!(is_first && edge_cnt == 5'd0 && !sample_edge_select)) begin
                        data_out <= out_bit;
                    end
                end
                if (fin) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                    rx_data <= rxsh;
                end
                if (!master && !ss_active && busy)
                    busy <= 1'b0;
            end
        end
    end
endmodule // spi_shifter

// ==== rtl/spi_master_slave_port.v ====
// How it works
// - Clock idle level follows the polarity bit: 0 low, 1 high.
// - Phase 0 samples on first clock edge, phase 1 on second.
// - Transfer-done flag set by hardware at each transfer end.
// - Done flag cleared on interrupt vectoring or by writing 0.
// - Collision flag set when data written while busy.
// - Collision flag cleared by writing 0 or a data write when not busy.
// - Master with select pin enabled: select low sets mode fault; write 0 clears.
// - Mode fault clears enable and master bits.
// - Overrun set when transfer ends with full still set; write 0 or data read clears.
// - Full flag set at transfer end; write 0 or data read clears.
// - Busy flag is read only and high during a transfer.
// - Data write when enabled and not busy loads shift register; in master mode starts transfer.
// - Data read returns receive buffer, not shift register.
// - Priority is two bits: low bit and high bit in two registers.
// - Request reaches CPU on port_irq only with port and global enables set; irq is gated by the mask alone.
`include "spi_port_map.vh"
module spi_master_slave_port #(
    parameter W = 8
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    input wire irq_vectored,
    input wire sck_i,
    output wire sck_o,
    output wire sck_oe,
    input wire mosi_i,
    output wire mosi_o,
    output wire mosi_oe,
    input wire miso_i,
    output wire miso_o,
    output wire miso_oe,
    input wire ss_n_i,
    output wire port_irq,
    output wire [1:0] port_priority,
    output wire irq
);
    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    reg [3:0] sync1;
    reg [3:0] sync2;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1 <= 4'hF;
            sync2 <= 4'hF;
        end else begin
            sync1 <= {sck_i, mosi_i, miso_i, ss_n_i};
            sync2 <= sync1;
        end
    end
    wire sck_s = sync2[3];
    wire mosi_s = sync2[2];
    wire miso_s = sync2[1];
    wire ss_n_s = sync2[0];

    // ----------------------------------------
    // AHB-Lite slave
    // ----------------------------------------
    reg ph_wr;
    reg ph_rd;
    reg [7:0] ph_idx;
    wire take = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_wr <= 1'b0;
            ph_rd <= 1'b0;
            ph_idx <= 8'h00;
        end else begin
            ph_wr <= take && hwrite;
            ph_rd <= take && !hwrite;
            ph_idx <= haddr[9:2];
        end
    end
    function is_reg;
        input [7:0] idx;
        input [7:0] want;
        begin
            is_reg = (idx == want);
        end
    endfunction
    wire [7:0] wb = hwdata[7:0];
    wire wr_ctl = ph_wr && is_reg(ph_idx, `IDX_CONTROL);
    wire wr_sta = ph_wr && is_reg(ph_idx, `IDX_STATUS);
    wire wr_dat = ph_wr && is_reg(ph_idx, `IDX_DATA);
    wire rd_dat = ph_rd && is_reg(ph_idx, `IDX_DATA);

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg [7:0] control;
    reg [7:0] prio_low;
    reg [7:0] prio_high;
    reg [1:0] irq_enable;
    reg [7:0] irq_mask;
    reg [7:0] irq_status;
    reg f_done;
    reg f_write_collision_flag;
    reg f_mode_fault_flag;
    reg f_ovf;
    reg f_full;
    wire busy;
    wire done;
    wire [W-1:0] rx_data;
    wire en = control[`CTL_ENABLE];
    wire master = control[`CTL_MASTER];
    wire ss_act = !ss_n_s;
    wire mode_fault_flag_ev = en && master && !control[`CTL_SELECT_PIN_DISABLE] && ss_act;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            control <= `RST_BYTE;
            prio_low <= `RST_BYTE;
            prio_high <= `RST_BYTE;
            irq_enable <= 2'b00;
            irq_mask <= `RST_BYTE;
        end else begin
            if (wr_ctl)
                control <= wb;
            if (mode_fault_flag_ev) begin
                control[`CTL_ENABLE] <= 1'b0;
                control[`CTL_MASTER] <= 1'b0;
            end
            if (ph_wr && is_reg(ph_idx, `IDX_PRIO_LOW))
                prio_low <= wb;
            if (ph_wr && is_reg(ph_idx, `IDX_PRIO_HIGH))
                prio_high <= wb;
            if (ph_wr && is_reg(ph_idx, `IDX_IRQ_ENABLE))
                irq_enable <= wb[1:0];
            if (ph_wr && is_reg(ph_idx, `IDX_IRQ_MASK))
                irq_mask <= wb;
        end
    end

    // ----------------------------------------
    // Status flags (set wins over clear)
    // ----------------------------------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            f_done <= 1'b0;
            f_write_collision_flag <= 1'b0;
            f_mode_fault_flag <= 1'b0;
            f_ovf <= 1'b0;
            f_full <= 1'b0;
        end else begin
            if (done)
                f_done <= 1'b1;
            else if (irq_vectored || (wr_sta && !wb[`ST_DONE]))
                f_done <= 1'b0;
            if (wr_dat && busy)
                f_write_collision_flag <= 1'b1;
            else if ((wr_sta && !wb[`ST_WRITE_COLLISION_FLAG]) || wr_dat)
                f_write_collision_flag <= 1'b0;
            if (mode_fault_flag_ev)
                f_mode_fault_flag <= 1'b1;
            else if (wr_sta && !wb[`ST_MODE_FAULT_FLAG])
                f_mode_fault_flag <= 1'b0;
            if (done && f_full)
                f_ovf <= 1'b1;
            else if ((wr_sta && !wb[`ST_OVF]) || rd_dat)
                f_ovf <= 1'b0;
            if (done)
                f_full <= 1'b1;
            else if ((wr_sta && !wb[`ST_FULL]) || rd_dat)
                f_full <= 1'b0;
        end
    end
    wire [7:0] status = {f_done, f_write_collision_flag, f_mode_fault_flag, f_ovf, f_full, busy, 2'b00};

    // ----------------------------------------
    // Interrupt block
    // ----------------------------------------
    wire [7:0] events = {done, wr_dat && busy, mode_fault_flag_ev, done && f_full, done, 3'b000};
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            irq_status <= `RST_BYTE;
        else
            irq_status <= events
                | (irq_status & ~((ph_wr && is_reg(ph_idx, `IDX_IRQ_STATUS)) ? wb : 8'h00));
    end
    assign irq = |(irq_status & irq_mask);
    assign port_irq = irq_enable[`IE_PORT] && irq_enable[`IE_GLOBAL]
        && (f_done | f_mode_fault_flag | f_write_collision_flag);
    assign port_priority = {prio_high[`PRIO_BIT], prio_low[`PRIO_BIT]};

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (take && !hwrite) begin
            case (haddr[9:2])
                `IDX_PRIO_LOW: hrdata <= {24'h000000, prio_low};
                `IDX_PRIO_HIGH: hrdata <= {24'h000000, prio_high};
                `IDX_CONTROL: hrdata <= {24'h000000, control};
                `IDX_STATUS: hrdata <= {24'h000000, status};
                `IDX_DATA: hrdata <= {24'h000000, rx_data};
                `IDX_IRQ_ENABLE: hrdata <= {30'h00000000, irq_enable};
                `IDX_IRQ_MASK: hrdata <= {24'h000000, irq_mask};
                `IDX_IRQ_STATUS: hrdata <= {24'h000000, irq_status};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------
    // Shifter and pins
    // ----------------------------------------
    wire sck_drv;
    wire dout;
    spi_shifter #(.W(W)) u_shift (
        .hclk(hclk),
        .hresetn(hresetn),
        .active(en),
        .master(master),
        .clock_idle_level(control[`CTL_CLOCK_IDLE_LEVEL]),
        .sample_edge_select(control[`CTL_SAMPLE_EDGE_SELECT]),
        .bit_order_select(control[`CTL_BIT_ORDER_SELECT]),
        .rate(control[1:0]),
        .load(wr_dat && !busy),
        .load_data(wb),
        .sck_in(sck_s),
        .ss_active(ss_act || control[`CTL_SELECT_PIN_DISABLE]),
        .miso_in(miso_s),
        .mosi_in(mosi_s),
        .sck_out(sck_drv),
        .data_out(dout),
        .busy(busy),
        .done(done),
        .rx_data(rx_data)
    );
    assign sck_o = sck_drv;
    assign sck_oe = en && master;
    assign mosi_o = dout;
    assign mosi_oe = en && master;
    assign miso_o = dout;
    assign miso_oe = en && !master && ss_act;
endmodule // spi_master_slave_port

// ==== dv/spi_port_assertions.sv ====
// ----
// Bus and pin checks
// ----
module spi_port_checker (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    input wire [31:0] hrdata,
    input wire sck_oe,
    input wire miso_oe,
    input wire [1:0] port_priority
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire take = hsel && hready && htrans[1];
    wire rd = take && !hwrite;
    wire wr = take && hwrite;
    chk_resp_okay: assert property (hresp == 1'b0)
        else $error("error response seen");
    chk_zero_wait: assert property (hreadyout == 1'b1)
        else $error("wait state seen");
    chk_rd_unmapped: assert property (rd && haddr[11:2] == 10'h000 |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    chk_prio_low: assert property (rd && haddr[11:2] == 10'h0BA |=> hrdata[4] == port_priority[0])
        else $error("priority low bit differs");
    chk_prio_high: assert property (rd && haddr[11:2] == 10'h0BB |=> hrdata[4] == port_priority[1])
        else $error("priority high bit differs");
    chk_prio_cause: assert property ($changed(port_priority) |-> $past(wr) || $past(wr, 2))
        else $error("priority moved without a write");
    chk_rd_stands: assert property (!$past(rd) |-> $stable(hrdata))
        else $error("read data moved without a read");
    chk_pin_roles: assert property (sck_oe |-> !miso_oe)
        else $error("master and slave pins driven together");
endmodule // spi_port_checker
bind spi_master_slave_port spi_port_checker chk_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .sck_oe(sck_oe), .miso_oe(miso_oe),
    .port_priority(port_priority));

// ==== dv/spi_far_end.sv ====
// ----
// Far side device, clock mode 0
// ----
module spi_far_end (
    input wire ss_n,
    input wire go,
    input wire [7:0] tx,
    input wire sck_in,
    input wire mosi_in,
    input wire miso_in,
    output logic sck_out,
    output wire mosi_out,
    output wire miso_out,
    output logic [7:0] rx
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] sh = 8'h00;
    logic last = 1'b0;
    logic mbit = 1'b0;
    initial sck_out = 1'b0;
    initial rx = 8'h00;
    always @(posedge go) begin
        #3;
        for (int i = 7; i >= 0; i--) begin
            mbit = tx[i];
            #40 sck_out = 1'b1;
            rx = {rx[6:0], miso_in};
            #40 sck_out = 1'b0;
        end
    end
    always @(negedge ss_n) sh = tx;
    always @(posedge sck_in) begin
        if (!ss_n && !go) begin
            rx <= {rx[6:0], mosi_in};
            last <= sh[7];
        end
    end
    always @(negedge sck_in) begin
        if (!ss_n && !go) sh <= {sh[6:0], 1'b0};
    end
    assign miso_out = ss_n ? ~last : sh[7];
    assign mosi_out = go ? mbit : ~mbit;
endmodule // spi_far_end

// ==== dv/tb.sv ====
`include "spi_port_map.vh"
// ----
// Register level bench
// ----
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk, hresetn, hsel, hwrite, irq_vectored, ss_n, go;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, q;
    logic [7:0] ptx;
    logic [7:0] regs [6] = '{`IDX_PRIO_LOW, `IDX_PRIO_HIGH, `IDX_CONTROL, `IDX_STATUS,
        `IDX_DATA, 8'h00};
    wire hreadyout, hresp, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
    wire port_irq, irq, p_sck, p_mosi, p_miso;
    wire [31:0] hrdata;
    wire [1:0] port_priority;
    wire [7:0] prx;
    wire sck_w = sck_oe ? sck_o : p_sck;
    wire mosi_w = mosi_oe ? mosi_o : p_mosi;
    wire miso_w = miso_oe ? miso_o : p_miso;
    int err_total = 0;
    int n_tests = 0;
    time t0 = 0;
    time per = 0;
    spi_master_slave_port uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq_vectored(irq_vectored),
        .sck_i(sck_w), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi_w), .mosi_o(mosi_o),
        .mosi_oe(mosi_oe), .miso_i(miso_w), .miso_o(miso_o), .miso_oe(miso_oe), .ss_n_i(ss_n),
        .port_irq(port_irq), .port_priority(port_priority), .irq(irq));
    spi_far_end far (.ss_n(ss_n), .go(go), .tx(ptx), .sck_in(sck_w), .mosi_in(mosi_w),
        .miso_in(miso_w), .sck_out(p_sck), .mosi_out(p_mosi), .miso_out(p_miso), .rx(prx));
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    always @(posedge sck_w) begin
        per = $time - t0;
        t0 = $time;
    end
    task automatic end_sim;
        if (err_total == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic bus(input logic [7:0] idx, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'b00};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rc(input logic [7:0] idx, input logic [31:0] exp);
        bus(idx, 1'b0, 32'h0);
        chk(q, exp);
    endtask
    task automatic tick;
        repeat (2) @(posedge hclk);
    endtask
    task automatic xfer(input logic [7:0] d, input logic coll);
        ss_n <= 1'b0;
        bus(`IDX_DATA, 1'b1, {24'h0, d});
        if (coll) bus(`IDX_DATA, 1'b1, 32'h33);
        tick;
        do bus(`IDX_STATUS, 1'b0, 32'h0); while (q[`ST_BUSY] !== 1'b0);
        ss_n <= 1'b1;
        @(posedge hclk);
    endtask
    initial begin
        #100us;
        err_total++;
        end_sim;
    end
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        hwrite = 1'b0;
        htrans = 2'b00;
        hwdata = 32'h0;
        irq_vectored = 1'b0;
        ss_n = 1'b1;
        go = 1'b0;
        ptx = 8'h35;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (regs[i]) rc(regs[i], 32'h0);
        bus(`IDX_PRIO_LOW, 1'b1, 32'h10);
        bus(`IDX_PRIO_HIGH, 1'b1, 32'h10);
        tick;
        chk({30'h0, port_priority}, 32'h3);
        rc(`IDX_PRIO_HIGH, 32'h10);
        bus(`IDX_IRQ_ENABLE, 1'b1, 32'h3);
        bus(`IDX_IRQ_MASK, 1'b1, 32'hFF);
        for (int r = 0; r < 5; r++) begin
            bus(`IDX_CONTROL, 1'b1, r < 4 ? 32'hC8 + r : 32'hCC);
            xfer(8'hA1, 1'b0);
            chk(per[31:0], 32'h14 << (r % 4));
            chk({24'h0, prx}, r < 4 ? 32'hA1 : 32'h85);
            rc(`IDX_STATUS, 32'h88);
            rc(`IDX_DATA, r < 4 ? 32'h35 : 32'hAC);
            rc(`IDX_STATUS, 32'h80);
            bus(`IDX_STATUS, 1'b1, 32'h0);
        end
        bus(`IDX_CONTROL, 1'b1, 32'hCB);
        xfer(8'h11, 1'b0);
        xfer(8'h22, 1'b1);
        chk({24'h0, prx}, 32'h22);
        rc(`IDX_STATUS, 32'hD8);
        rc(`IDX_DATA, 32'h35);
        rc(`IDX_STATUS, 32'hC0);
        xfer(8'h44, 1'b0);
        rc(`IDX_STATUS, 32'h88);
        chk({31'h0, port_irq}, 32'h1);
        chk({31'h0, irq}, 32'h1);
        bus(`IDX_IRQ_ENABLE, 1'b1, 32'h2);
        tick;
        chk({31'h0, port_irq}, 32'h0);
        bus(`IDX_IRQ_MASK, 1'b1, 32'h0);
        tick;
        chk({31'h0, irq}, 32'h0);
        bus(`IDX_IRQ_MASK, 1'b1, 32'hFF);
        bus(`IDX_IRQ_STATUS, 1'b1, 32'hFF);
        tick;
        chk({31'h0, irq}, 32'h0);
        irq_vectored <= 1'b1;
        @(posedge hclk);
        irq_vectored <= 1'b0;
        rc(`IDX_STATUS, 32'h08);
        bus(`IDX_CONTROL, 1'b1, 32'hE8);
        tick;
        chk({31'h0, sck_o}, 32'h1);
        chk({31'h0, sck_oe}, 32'h1);
        ss_n <= 1'b0;
        bus(`IDX_CONTROL, 1'b1, 32'hC0);
        tick;
        rc(`IDX_CONTROL, 32'h0);
        chk({30'h0, sck_oe, mosi_oe}, 32'h0);
        rc(`IDX_STATUS, 32'h28);
        bus(`IDX_STATUS, 1'b1, 32'h0);
        bus(`IDX_DATA, 1'b1, 32'h77);
        tick;
        rc(`IDX_STATUS, 32'h0);
        ss_n <= 1'b1;
        bus(`IDX_CONTROL, 1'b1, 32'h80);
        bus(`IDX_DATA, 1'b1, 32'h96);
        ptx <= 8'h5A;
        ss_n <= 1'b0;
        go <= 1'b1;
        repeat (70) @(posedge hclk);
        chk({30'h0, miso_oe, mosi_oe}, 32'h2);
        go <= 1'b0;
        ss_n <= 1'b1;
        tick;
        chk({24'h0, prx}, 32'h96);
        rc(`IDX_DATA, 32'h5A);
        end_sim;
    end
endmodule // tb
